// ### inc/adc_cfg_pkg.sv
// Package: register map, field layout, reset values and divider codes for the converter configuration block
package adc_cfg_pkg;
	// Register indices on the plain register port
	localparam logic [1:0] CTRL_ONE_ADDR = 2'h0;
	localparam logic [1:0] PIN_EN_ADDR   = 2'h1;
	localparam logic [1:0] STATUS_ADDR   = 2'h2;
	// Field positions in the converter control register
	localparam int BGSEL_BIT = 7;
	localparam int BGEN_BIT  = 6;
	localparam int REFSEL_BIT = 4;
	localparam int DIV_LSB   = 0;
	localparam int DIV_MSB   = 2;
	// Writable bits of the control register; the rest read as zero
	localparam logic [7:0] CTRL_ONE_MASK  = 8'hD7;
	localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
	localparam logic [7:0] PIN_EN_RESET   = 8'hFF;
	// Divider codes
	localparam logic [2:0] DIV_CODE_UNDEF = 3'h7;
	localparam int         DIV_CNT_W      = 6;
endpackage : adc_cfg_pkg

// ### rtl/adc_input_reference_select.sv
// Converter input, bandgap, reference and clock divider configuration
`timescale 1ns/100ps
//
// Functional notes
// - Bandgap select routes bandgap when enable is also set, drops other channels
// - Bandgap enable bit switches circuit on/off
// - Bandgap auto off when unused and monitors off
// - Reference select: 0 supply, 1 pin
// - Divider codes 000,001,010 give 1,2,4
// - Unimplemented control bits ignore writes, read zero
// - Pin enable bits make pins analog channels
// - Reset: pin enables one, control zero
module adc_input_reference_select
(
	input  wire logic       clk_i,
	input  wire logic       arst_n_i,
	input  wire logic [1:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       low_voltage_monitors_i,
	output logic            bandgap_power_o,
	output logic            bandgap_route_o,
	output logic      [7:0] analog_channel_en_o,
	output logic            reference_source_select_o,
	output logic            converter_clk_en_o
);

	//****************************************
	// Reset release and monitor input sync
	//****************************************
	logic       rst_s1_r;
	logic       rst_n_r;
	logic       mon_s1_r;
	logic       mon_r;

	// Two stage release keeps deassertion glitch free
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rst_s1_r <= 1'b0;
			rst_n_r  <= 1'b0;
		end
		else
		begin
			rst_s1_r <= 1'b1;
			rst_n_r  <= rst_s1_r;
		end
	end

	// Monitor enable comes from another block's domain
	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			mon_s1_r <= 1'b0;
			mon_r    <= 1'b0;
		end
		else
		begin
			mon_s1_r <= low_voltage_monitors_i;
			mon_r    <= mon_s1_r;
		end
	end

	//****************************************
	// Registers
	//****************************************
	logic [7:0] ctrl_one_r;
	logic [7:0] ctrl_one_nxt;
	logic [7:0] pin_en_r;
	logic [7:0] pin_en_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic       bandgap_on;

	// Write decode and read mux
	always_comb
	begin
		ctrl_one_nxt = ctrl_one_r;
		pin_en_nxt   = pin_en_r;
		rdata_nxt    = 8'h00;
		if (wr_i && addr_i == adc_cfg_pkg::CTRL_ONE_ADDR)
			ctrl_one_nxt = wdata_i & adc_cfg_pkg::CTRL_ONE_MASK;
		if (wr_i && addr_i == adc_cfg_pkg::PIN_EN_ADDR)
			pin_en_nxt = wdata_i;
		if (rd_i)
		begin
			case (addr_i)
				adc_cfg_pkg::CTRL_ONE_ADDR: rdata_nxt = ctrl_one_r;
				adc_cfg_pkg::PIN_EN_ADDR:   rdata_nxt = pin_en_r;
				adc_cfg_pkg::STATUS_ADDR:   rdata_nxt = {7'h00, bandgap_on};
				default:                    rdata_nxt = 8'h00;
			endcase
		end
	end

	// Reset values: pins analog, control cleared
	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			ctrl_one_r <= adc_cfg_pkg::CTRL_ONE_RESET;
			pin_en_r   <= adc_cfg_pkg::PIN_EN_RESET;
			rdata_r    <= 8'h00;
		end
		else
		begin
			ctrl_one_r <= ctrl_one_nxt;
			pin_en_r   <= pin_en_nxt;
			rdata_r    <= rdata_nxt;
		end
	end

	assign rdata_o = rdata_r;

	//****************************************
	// Bandgap, routing and reference
	//****************************************
	logic bgsel;
	logic bgen;
	logic [2:0] div_code;

	assign bgsel    = ctrl_one_r[adc_cfg_pkg::BGSEL_BIT];
	assign bgen     = ctrl_one_r[adc_cfg_pkg::BGEN_BIT];
	assign div_code = ctrl_one_r[adc_cfg_pkg::DIV_MSB:adc_cfg_pkg::DIV_LSB];

	// Powered if the converter wants it or the monitors need it
	assign bandgap_on      = bgen | mon_r;
	assign bandgap_power_o = bandgap_on;
	// Routing needs the enable too; selecting first is a software error
	assign bandgap_route_o = bgsel & bgen;
	// Bandgap select drops all external channels
	assign analog_channel_en_o       = bgsel ? 8'h00 : pin_en_r;
	assign reference_source_select_o = ctrl_one_r[adc_cfg_pkg::REFSEL_BIT];

	//****************************************
	// Converter clock divider
	//****************************************
	logic [adc_cfg_pkg::DIV_CNT_W-1:0] div_cnt_r;
	logic [adc_cfg_pkg::DIV_CNT_W-1:0] div_cnt_nxt;
	logic [adc_cfg_pkg::DIV_CNT_W-1:0] div_mask;
	logic                              tick_r;
	logic                              tick_nxt;

	// Enable pulse once per 2^code system clocks; code 111 stops the clock
	always_comb
	begin
		div_mask    = adc_cfg_pkg::DIV_CNT_W'((7'h01 << div_code) - 7'h01);
		div_cnt_nxt = (div_cnt_r & div_mask) == div_mask ? '0 : div_cnt_r + adc_cfg_pkg::DIV_CNT_W'(1);
		tick_nxt    = (div_code != adc_cfg_pkg::DIV_CODE_UNDEF) &&
		              ((div_cnt_r & div_mask) == div_mask);
	end

	always_ff @(posedge clk_i or negedge rst_n_r)
	begin
		if (!rst_n_r)
		begin
			div_cnt_r <= '0;
			tick_r    <= 1'b0;
		end
		else
		begin
			div_cnt_r <= div_cnt_nxt;
			tick_r    <= tick_nxt;
		end
	end

	assign converter_clk_en_o = tick_r;

	//****************************************
	// Assertions
	//****************************************
	property p_route;
		@(posedge clk_i) disable iff (!rst_n_r)
		bgsel |-> analog_channel_en_o == 8'h00;
	endproperty
	a_route: assert property (p_route) else $error("channels live while bandgap routed");

	property p_power;
		@(posedge clk_i) disable iff (!rst_n_r)
		bandgap_route_o |-> bandgap_power_o;
	endproperty
	a_power: assert property (p_power) else $error("bandgap routed while off");

	property p_autooff;
		@(posedge clk_i) disable iff (!rst_n_r)
		(!bgen && !mon_r) |-> !bandgap_power_o;
	endproperty
	a_autooff: assert property (p_autooff) else $error("bandgap not switched off");

	property p_ref;
		@(posedge clk_i) disable iff (!rst_n_r)
		(wr_i && addr_i == adc_cfg_pkg::CTRL_ONE_ADDR) |=>
			reference_source_select_o == $past(wdata_i[adc_cfg_pkg::REFSEL_BIT]);
	endproperty
	a_ref: assert property (p_ref) else $error("reference select not taken");

	property p_div1;
		@(posedge clk_i) disable iff (!rst_n_r)
		(div_code == 3'h0) [*3] |-> converter_clk_en_o;
	endproperty
	a_div1: assert property (p_div1) else $error("undivided clock missing");

	property p_div2;
		@(posedge clk_i) disable iff (!rst_n_r)
		(div_code == 3'h1) [*4] ##0 converter_clk_en_o |-> !$past(converter_clk_en_o);
	endproperty
	a_div2: assert property (p_div2) else $error("divide by two wrong");

	property p_rsvd;
		@(posedge clk_i) disable iff (!rst_n_r)
		(ctrl_one_r & ~adc_cfg_pkg::CTRL_ONE_MASK) == 8'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bit set");

	property p_pins;
		@(posedge clk_i) disable iff (!rst_n_r)
		(wr_i && addr_i == adc_cfg_pkg::PIN_EN_ADDR) |=> pin_en_r == $past(wdata_i);
	endproperty
	a_pins: assert property (p_pins) else $error("pin enable write lost");

	property p_undef;
		@(posedge clk_i) disable iff (!rst_n_r)
		(div_code == adc_cfg_pkg::DIV_CODE_UNDEF) [*2] |-> !converter_clk_en_o;
	endproperty
	a_undef: assert property (p_undef) else $error("clock on undefined code");

	c_route:  cover property (@(posedge clk_i) disable iff (!rst_n_r) bandgap_route_o);
	c_div64:  cover property (@(posedge clk_i) disable iff (!rst_n_r) div_code == 3'h6 && converter_clk_en_o);
	c_refpin: cover property (@(posedge clk_i) disable iff (!rst_n_r) reference_source_select_o);

endmodule // adc_input_reference_select

// ### tb/tb_top.sv
// Self-checking bench for the converter configuration block
`timescale 1ns/100ps
module tb_top;
	logic       clk_i = 1'b0;
	logic       arst_n_i = 1'b0;
	logic [1:0] addr_i = 2'h0;
	logic [7:0] wdata_i = 8'h00;
	logic       wr_i = 1'b0;
	logic       rd_i = 1'b0;
	logic       mon_i = 1'b0;
	logic [7:0] rdata_o;
	logic       bg_pwr;
	logic       bg_route;
	logic [7:0] chan_en;
	logic       ref_sel;
	logic       clk_en;
	int         fail_count = 0;
	int         num_checks = 0;
	logic [7:0] rv;
	logic [7:0] c;
	logic [7:0] p;
	int         cnt;

	// Bench's own settling allowance between enable and select; value is arbitrary
	localparam int SETTLE_CYCLES = 4;

	adc_input_reference_select dut
	(
		.clk_i                     (clk_i),
		.arst_n_i                  (arst_n_i),
		.addr_i                    (addr_i),
		.wdata_i                   (wdata_i),
		.wr_i                      (wr_i),
		.rd_i                      (rd_i),
		.rdata_o                   (rdata_o),
		.low_voltage_monitors_i    (mon_i),
		.bandgap_power_o           (bg_pwr),
		.bandgap_route_o           (bg_route),
		.analog_channel_en_o       (chan_en),
		.reference_source_select_o (ref_sel),
		.converter_clk_en_o        (clk_en)
	);

	// Half period of 2.5 ns gives 200 MHz
	always #2.5 clk_i = ~clk_i;

	// ****************************************
	// Bench tasks
	// ****************************************
	task automatic finish_test;
		$display("checks=%0d mismatches=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Expected channel enables: select hides every external pin
	function automatic logic [7:0] exp_chan(input logic [7:0] ctrl, input logic [7:0] pins);
		return ctrl[adc_cfg_pkg::BGSEL_BIT] ? 8'h00 : pins;
	endfunction

	// Ticks in a 128-cycle window: 2^code apart, none for the undefined code
	function automatic logic [7:0] exp_ticks(input int code);
		return (code == int'(adc_cfg_pkg::DIV_CODE_UNDEF)) ? 8'h00 : 8'(128 >> code);
	endfunction

	// One-cycle strobes, changed just after the edge
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
		#1;
	endtask

	// Data is only valid in the cycle after the strobe
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 d = rdata_o;
	endtask

	// Hang guard well above the longest sequence
	initial
	begin
		#100000;
		fail_count++;
		finish_test();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		void'($urandom(32'h0AC8));
		repeat (5) @(posedge clk_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		// Power-on values
		rd(2'h0, rv); chk(rv, 8'h00);
		rd(2'h1, rv); chk(rv, 8'hFF);
		chk(chan_en, 8'hFF);
		chk({7'h0, bg_pwr}, 8'h00);
		// Holes in the control register and the unmapped index
		wr(2'h0, 8'hFF);
		rd(2'h0, rv); chk(rv, adc_cfg_pkg::CTRL_ONE_MASK);
		wr(2'h3, 8'hA5);
		rd(2'h3, rv); chk(rv, 8'h00);
		$display("reset and map test done");
		// Random control, pin enables and monitor demand
		for (int i = 0; i < 12; i++)
		begin
			c = 8'($urandom());
			p = (i == 0) ? 8'h00 : 8'($urandom());
			// Software never selects the bandgap without enabling it first
			if (c[adc_cfg_pkg::BGSEL_BIT])
				c[adc_cfg_pkg::BGEN_BIT] = 1'b1;
			mon_i <= (i % 3 == 1);
			wr(2'h0, c & 8'h7F);
			repeat (SETTLE_CYCLES) @(posedge clk_i);
			wr(2'h0, c);
			wr(2'h1, p);
			rd(2'h1, rv); chk(rv, p);
			chk(chan_en, exp_chan(c, p));
			chk({7'h0, bg_route}, {7'h0, c[7] & c[6]});
			chk({7'h0, bg_pwr}, {7'h0, c[6] | (i % 3 == 1)});
			chk({7'h0, ref_sel}, {7'h0, c[4]});
			rd(2'h2, rv); chk(rv & 8'h01, {7'h0, c[6] | (i % 3 == 1)});
		end
		$display("random field test done");
		// Every divider code: count ticks in a 128-cycle window
		for (int code = 0; code < 8; code++)
		begin
			wr(2'h0, 8'(code));
			repeat (64) @(posedge clk_i);
			cnt = 0;
			repeat (128)
			begin
				@(posedge clk_i);
				#1 if (clk_en === 1'b1) cnt++;
			end
			chk(8'(cnt), exp_ticks(code));
		end
		$display("divider test done");
		finish_test();
	end
endmodule // tb_top
